//--- pai_far_agent.sv
// far-side pci memory target answering the master
`timescale 1ns/10ps
module pai_far_agent import pai_pkg::*; (
    input wire logic clk,
    input wire logic slow,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic [3:0] cbe,
    output logic devsel_n,
    output logic trdy_n,
    output logic oe,
    output logic [31:0] rdata,
    output logic rd_oe,
    output logic [3:0] cmd,
    output logic [7:0] words
);
    logic pf = 1'b1;
    logic sel = 1'b0;
    logic tgl = 1'b0;
    assign devsel_n = !sel;
    assign trdy_n = !(sel && !irdy_n && (!slow || tgl));
    assign oe = sel;
    assign rdata = {24'hA5A5A5, words};
    assign rd_oe = sel && cmd == CMD_MEM_RD;
    always_ff @(posedge clk) begin
        pf <= frame_n;
        tgl <= !tgl;
        if (!frame_n && pf && (cbe == CMD_MEM_RD || cbe == CMD_MEM_WR)) begin
            sel <= 1'b1;
            cmd <= cbe;
            words <= 8'h00;
        end else if (!trdy_n) begin
            words <= words + 8'h01;
            sel <= !frame_n;
        end
    end
endmodule : pai_far_agent

//--- pai_pci_if.sv
// pci target, master, arbiter, datapath and read fifo of the audio host interface
`timescale 1ns/10ps
module pai_fifo import pai_pkg::*; #(
    parameter int WIDTH = pai_pkg::FIFO_WIDTH,
    parameter int DEPTH = pai_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] fill
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic push;
    logic pop;

    assign in_ready = fill != (AW+1)'(DEPTH);
    assign out_valid = fill != '0;
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wp <= '0;
            rp <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : pai_fifo

module pai_pci_if import pai_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    input wire logic [3:0] cbe_in,
    output logic [3:0] cbe_out,
    output logic cbe_oe,
    input wire logic frame_n_in,
    output logic frame_n_out,
    output logic frame_n_oe,
    input wire logic irdy_n_in,
    output logic irdy_n_out,
    output logic irdy_n_oe,
    input wire logic trdy_n_in,
    output logic trdy_n_out,
    output logic trdy_n_oe,
    input wire logic devsel_n_in,
    output logic devsel_n_out,
    output logic devsel_n_oe,
    input wire logic stop_n_in,
    output logic stop_n_out,
    output logic stop_n_oe,
    input wire logic idsel,
    output logic req_n,
    input wire logic gnt_n,
    input wire logic legacy_dma_grant,
    input wire pai_pkg::pai_io_win_t [pai_pkg::NUM_WIN-1:0] io_map,
    output pai_pkg::pai_ps_req_t ps_req,
    input wire logic ps_ack,
    input wire logic [31:0] ps_rdata,
    output logic sig_target_abort,
    input wire pai_pkg::pai_pm_req_t dma_req,
    input wire pai_pkg::pai_pm_req_t vreg_req,
    output logic dma_gnt,
    output logic vreg_gnt,
    input wire logic [31:0] pm_wdata,
    input wire logic pm_wvalid,
    output logic pm_wready,
    output logic [31:0] pm_rdata,
    output logic pm_rvalid,
    input wire logic pm_rready,
    output logic pm_done,
    output logic pm_err
);
    localparam int FAW = $clog2(FIFO_DEPTH);

    function automatic logic [3:0] win_find(input pai_io_win_t [NUM_WIN-1:0] map, input logic [31:0] a);
        logic [3:0] r;
        r = '0;
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (map[i].en && a[31:16] == 16'h0000 && (a[15:0] & ~map[i].mask) == map[i].base) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : win_find

    function automatic pai_dev_t win_class(input logic [2:0] w);
        case (w)
            WIN_CODEC: return DEV_WORD;
            WIN_DSP: return DEV_BYTE_WORD;
            WIN_DMA: return DEV_ANY;
            default: return DEV_BYTE;
        endcase
    endfunction : win_class

    function automatic logic [2:0] be_count(input logic [3:0] be_n);
        return 3'(!be_n[0]) + 3'(!be_n[1]) + 3'(!be_n[2]) + 3'(!be_n[3]);
    endfunction : be_count

    function automatic logic width_ok(input logic cfg, input pai_dev_t dev, input logic [3:0] be_n);
        logic [3:0] en;
        logic contig;
        logic word;
        en = ~be_n;
        word = en == 4'h3 || en == 4'hC;
        case (en)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF: contig = 1'b1;
            default: contig = 1'b0;
        endcase
        if (cfg) begin
            return contig;
        end
        if (be_count(be_n) > 3'h2) begin
            return 1'b0;
        end
        case (dev)
            DEV_BYTE: return be_count(be_n) == 3'h1;
            DEV_WORD: return word;
            DEV_BYTE_WORD: return be_count(be_n) == 3'h1 || word;
            DEV_ANY: return contig;
            default: return 1'b0;
        endcase
    endfunction : width_ok

    pai_tstate_t t_state;
    pai_mstate_t m_state;
    logic frame_q;
    logic t_start;
    logic fast_hit;
    logic [31:0] t_addr;
    logic [3:0] t_cmd;
    logic t_idsel;
    logic t_cfg;
    logic [3:0] dec;
    logic claim_io;
    logic claim_cfg;
    pai_dev_t t_dev;
    logic [2:0] t_win;
    logic [31:0] t_ad;
    logic t_ad_oe;
    logic t_oe;
    logic m_own;
    logic m_write;
    logic [7:0] m_left;
    logic [7:0] m_ld;
    logic m_slot;
    logic m_end;
    logic m_err;
    logic [2:0] m_dto;
    logic [31:0] m_ad;
    logic m_ad_oe;
    logic m_oe;
    logic m_xfer;
    logic m_abort;
    logic load_now;
    logic next_slot;
    logic next_irdy_on;
    logic [7:0] next_left;
    logic [FAW:0] fill;
    logic [FAW:0] room;
    logic fifo_in_ready;
    pai_pm_req_t cur;

    // target address phase capture and decode
    assign t_start = frame_q && !frame_n_in;
    assign fast_hit = legacy_dma_grant && cbe_in == CMD_IO_WR && (ad_in[15:0] == LEGACY_ADDR0 || ad_in[15:0] == LEGACY_ADDR1);
    assign t_cfg = t_cmd == CMD_CFG_RD || t_cmd == CMD_CFG_WR;
    assign dec = win_find(io_map, t_addr);
    assign claim_io = (t_cmd == CMD_IO_RD || t_cmd == CMD_IO_WR) && dec[3];
    assign claim_cfg = t_cfg && t_idsel && t_addr[1:0] == 2'b00 && t_addr[10:8] < NUM_FUNCS;

    // shared ad pins: master owns them while it holds the bus
    assign m_own = m_state == M_ADDR || m_state == M_DATA || m_state == M_TURN;
    assign ad_out = m_own ? m_ad : t_ad;
    assign ad_oe = m_own ? m_ad_oe : t_ad_oe;
    assign devsel_n_oe = t_oe;
    assign trdy_n_oe = t_oe;
    assign stop_n_oe = t_oe;
    assign frame_n_oe = m_oe;
    assign irdy_n_oe = m_oe;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            frame_q <= 1'b1;
        end else begin
            frame_q <= frame_n_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            t_state <= T_IDLE;
            devsel_n_out <= 1'b1;
            trdy_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            t_oe <= 1'b0;
            t_ad <= '0;
            t_ad_oe <= 1'b0;
            t_addr <= '0;
            t_cmd <= CMD_INT_ACK;
            t_idsel <= 1'b0;
            t_win <= '0;
            t_dev <= DEV_NONE;
            ps_req <= '0;
            sig_target_abort <= 1'b0;
        end else begin
            sig_target_abort <= 1'b0;
            case (t_state)
                T_IDLE: begin
                    if (t_start && !m_own) begin
                        t_addr <= ad_in;
                        t_cmd <= cbe_in;
                        t_idsel <= idsel;
                        if (fast_hit) begin
                            devsel_n_out <= 1'b0;
                            t_oe <= 1'b1;
                            t_win <= WIN_DMA;
                            t_dev <= DEV_ANY;
                            t_state <= T_WAIT;
                        end else begin
                            t_state <= T_DECODE;
                        end
                    end
                end
                T_DECODE: begin
                    if (claim_io || claim_cfg) begin
                        devsel_n_out <= 1'b0;
                        t_oe <= 1'b1;
                        t_win <= dec[2:0];
                        t_dev <= claim_cfg ? DEV_ANY : win_class(dec[2:0]);
                        t_state <= T_WAIT;
                    end else begin
                        t_state <= T_IDLE;
                    end
                end
                T_WAIT: begin
                    if (ps_req.valid) begin
                        if (ps_ack) begin
                            ps_req.valid <= 1'b0;
                            trdy_n_out <= 1'b0;
                            stop_n_out <= frame_n_in;
                            t_ad <= ps_rdata;
                            t_ad_oe <= !ps_req.write;
                            t_state <= T_DATA;
                        end
                    end else if (!irdy_n_in) begin
                        if (width_ok(t_cfg, t_dev, cbe_in)) begin
                            ps_req.valid <= 1'b1;
                            ps_req.write <= t_cmd[0];
                            ps_req.cfg <= t_cfg;
                            ps_req.func <= t_addr[10:8];
                            ps_req.dev <= t_dev;
                            ps_req.win <= t_win;
                            ps_req.addr <= t_addr;
                            ps_req.data <= ad_in;
                            ps_req.be_n <= cbe_in;
                        end else begin
                            devsel_n_out <= 1'b1;
                            stop_n_out <= 1'b0;
                            sig_target_abort <= 1'b1;
                            t_state <= T_ABORT;
                        end
                    end
                end
                T_DATA: begin
                    if (!irdy_n_in) begin
                        trdy_n_out <= 1'b1;
                        stop_n_out <= 1'b1;
                        devsel_n_out <= 1'b1;
                        t_ad_oe <= 1'b0;
                        t_state <= T_TURN;
                    end
                end
                T_ABORT: begin
                    if (frame_n_in) begin
                        stop_n_out <= 1'b1;
                        t_state <= T_TURN;
                    end
                end
                T_TURN: begin
                    t_oe <= 1'b0;
                    t_state <= T_IDLE;
                end
                default: begin
                    t_state <= T_IDLE;
                end
            endcase
        end
    end

    // master: arbitration pick and data phase bookkeeping
    assign cur = dma_req.valid ? dma_req : vreg_req;
    assign m_xfer = m_state == M_DATA && !irdy_n_out && !trdy_n_in;
    assign m_abort = devsel_n_in && m_dto == MABORT_CLKS;
    assign room = (FAW+1)'(FIFO_DEPTH) - fill;
    assign pm_wready = m_write && (m_state == M_ADDR || (m_state == M_DATA && !m_end)) && m_ld != 8'h00
        && (!m_slot || m_xfer);
    assign load_now = pm_wvalid && pm_wready;
    assign next_slot = load_now || (m_slot && !m_xfer);
    assign next_left = m_left - 8'(m_xfer);
    assign next_irdy_on = m_write ? next_slot
        : (next_left != 8'h00 && (room > (FAW+1)'(1) || (room == (FAW+1)'(1) && !m_xfer)));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            m_state <= M_IDLE;
            m_write <= 1'b0;
            m_left <= '0;
            m_ld <= '0;
            m_slot <= 1'b0;
            m_end <= 1'b0;
            m_err <= 1'b0;
            m_dto <= '0;
            m_ad <= '0;
            m_ad_oe <= 1'b0;
            m_oe <= 1'b0;
            req_n <= 1'b1;
            frame_n_out <= 1'b1;
            irdy_n_out <= 1'b1;
            cbe_out <= BE_ALL;
            cbe_oe <= 1'b0;
            dma_gnt <= 1'b0;
            vreg_gnt <= 1'b0;
            pm_done <= 1'b0;
            pm_err <= 1'b0;
        end else begin
            pm_done <= 1'b0;
            case (m_state)
                M_IDLE: begin
                    if (cur.valid && cur.len != 8'h00) begin
                        dma_gnt <= dma_req.valid;
                        vreg_gnt <= !dma_req.valid;
                        m_ad <= cur.addr;
                        m_write <= cur.write;
                        m_left <= cur.len;
                        m_ld <= cur.len;
                        m_err <= 1'b0;
                        req_n <= 1'b0;
                        m_state <= M_REQ;
                    end
                end
                M_REQ: begin
                    if (!gnt_n && frame_n_in && irdy_n_in && t_state == T_IDLE) begin
                        req_n <= 1'b1;
                        frame_n_out <= 1'b0;
                        irdy_n_out <= 1'b1;
                        m_oe <= 1'b1;
                        cbe_out <= m_write ? CMD_MEM_WR : CMD_MEM_RD;
                        cbe_oe <= 1'b1;
                        m_ad_oe <= 1'b1;
                        m_dto <= '0;
                        m_slot <= 1'b0;
                        m_end <= 1'b0;
                        m_state <= M_ADDR;
                    end
                end
                M_ADDR: begin
                    cbe_out <= BE_ALL;
                    m_ad_oe <= m_write;
                    if (load_now) begin
                        m_ad <= pm_wdata;
                        m_ld <= m_ld - 8'h01;
                    end
                    m_slot <= next_slot;
                    irdy_n_out <= !next_irdy_on;
                    frame_n_out <= next_left == 8'h01 && next_irdy_on;
                    m_state <= M_DATA;
                end
                M_DATA: begin
                    if (devsel_n_in && m_dto != MABORT_CLKS) begin
                        m_dto <= m_dto + 3'h1;
                    end
                    m_left <= next_left;
                    if (m_end) begin
                        irdy_n_out <= 1'b1;
                        m_state <= M_TURN;
                    end else if (!stop_n_in || m_abort) begin
                        m_err <= m_abort || next_left != 8'h00;
                        frame_n_out <= 1'b1;
                        m_end <= !frame_n_out;
                        irdy_n_out <= frame_n_out;
                        m_state <= frame_n_out ? M_TURN : M_DATA;
                    end else begin
                        if (load_now) begin
                            m_ad <= pm_wdata;
                            m_ld <= m_ld - 8'h01;
                        end
                        m_slot <= next_slot;
                        irdy_n_out <= !next_irdy_on;
                        if (next_left == 8'h01 && next_irdy_on) begin
                            frame_n_out <= 1'b1;
                        end
                        if (m_xfer && next_left == 8'h00) begin
                            irdy_n_out <= 1'b1;
                            m_ad_oe <= 1'b0;
                            m_state <= M_TURN;
                        end
                    end
                end
                M_TURN: begin
                    m_oe <= 1'b0;
                    cbe_oe <= 1'b0;
                    m_ad_oe <= 1'b0;
                    frame_n_out <= 1'b1;
                    irdy_n_out <= 1'b1;
                    pm_done <= 1'b1;
                    pm_err <= m_err;
                    dma_gnt <= 1'b0;
                    vreg_gnt <= 1'b0;
                    m_state <= M_IDLE;
                end
                default: begin
                    m_state <= M_IDLE;
                end
            endcase
        end
    end

    pai_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(ad_in),
        .in_valid(m_xfer && !m_write),
        .in_ready(fifo_in_ready),
        .out_data(pm_rdata),
        .out_valid(pm_rvalid),
        .out_ready(pm_rready),
        .fill(fill)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence medium_start_s;
        t_state == T_IDLE && t_start && !m_own && !fast_hit;
    endsequence

    sequence claimed_decode_s;
        t_state == T_DECODE && (claim_io || claim_cfg);
    endsequence

    io_claim_a: assert property (t_state == T_DECODE && claim_io |=> !devsel_n_out && devsel_n_oe)
        else $error("decoded io cycle not claimed");
    cfg_idsel_a: assert property (t_state == T_DECODE && t_cfg && !t_idsel |=> devsel_n_out)
        else $error("config cycle claimed without idsel");
    unclaimed_cmd_a: assert property (t_state == T_DECODE && !t_cfg && t_cmd[3:1] != 3'h1 |=> t_state == T_IDLE)
        else $error("unsupported command claimed");
    no_dac_a: assert property (cbe_oe && m_state == M_ADDR |-> cbe_out != CMD_DAC)
        else $error("dual address cycle generated");
    medium_devsel_a: assert property (medium_start_s ##1 claimed_decode_s |=> !devsel_n_out ##0 $past(devsel_n_out))
        else $error("medium devsel timing broken");
    fast_devsel_a: assert property (t_state == T_IDLE && t_start && !m_own && fast_hit |=> !devsel_n_out)
        else $error("fast devsel missing");
    io_width_a: assert property (t_state == T_WAIT && !ps_req.valid && !irdy_n_in && !t_cfg
        && be_count(cbe_in) > 3'h2 |=> t_state == T_ABORT && !stop_n_out && devsel_n_out)
        else $error("wide io access not aborted");
    all_bytes_a: assert property (m_state == M_DATA && !irdy_n_out |-> cbe_out == BE_ALL)
        else $error("master data phase with partial enables");
    lockout_a: assert property (m_own |-> devsel_n_out && trdy_n_out)
        else $error("target answered own master cycle");
    one_grant_a: assert property (!(dma_gnt && vreg_gnt))
        else $error("both internal masters granted");
    dma_first_a: assert property (m_state == M_IDLE && dma_req.valid && dma_req.len != 8'h00 |=> dma_gnt)
        else $error("arbiter priority broken");
    abort_flag_a: assert property (sig_target_abort |-> !stop_n_out && devsel_n_out && trdy_n_out ##1 !sig_target_abort)
        else $error("target abort signalling wrong");
    fifo_room_a: assert property (m_xfer && !m_write |-> fifo_in_ready)
        else $error("read data lost at full fifo");
endmodule : pai_pci_if

//--- pai_pkg.sv
// shared constants and types of the pci audio host interface
package pai_pkg;
    localparam logic [3:0] CMD_INT_ACK = 4'h0;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_DAC = 4'hD;
    localparam logic [3:0] BE_ALL = 4'h0;
    localparam logic [15:0] LEGACY_ADDR0 = 16'h0000;
    localparam logic [15:0] LEGACY_ADDR1 = 16'h0004;
    localparam logic [2:0] MABORT_CLKS = 3'h5;
    localparam logic [2:0] NUM_FUNCS = 3'h3;
    localparam int NUM_WIN = 7;
    localparam logic [2:0] WIN_GAME = 3'h0;
    localparam logic [2:0] WIN_SB = 3'h1;
    localparam logic [2:0] WIN_MIDI = 3'h2;
    localparam logic [2:0] WIN_UART = 3'h3;
    localparam logic [2:0] WIN_CODEC = 3'h4;
    localparam logic [2:0] WIN_DMA = 3'h5;
    localparam logic [2:0] WIN_DSP = 3'h6;
    localparam int FIFO_WIDTH = 32;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        DEV_NONE, DEV_BYTE, DEV_WORD, DEV_BYTE_WORD, DEV_ANY
    } pai_dev_t;

    typedef enum logic [2:0] {
        T_IDLE = 3'h0, T_DECODE = 3'h1, T_WAIT = 3'h3, T_DATA = 3'h2, T_TURN = 3'h6, T_ABORT = 3'h7
    } pai_tstate_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0, M_REQ = 3'h1, M_ADDR = 3'h3, M_DATA = 3'h2, M_TURN = 3'h6
    } pai_mstate_t;

    typedef struct packed {
        logic en;
        logic [15:0] base;
        logic [15:0] mask;
    } pai_io_win_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic cfg;
        logic [2:0] func;
        pai_dev_t dev;
        logic [2:0] win;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] be_n;
    } pai_ps_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [7:0] len;
    } pai_pm_req_t;
endpackage : pai_pkg

//--- pci_audio_host_interface_tb.sv
// self-checking bench of the pci audio host interface
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pci_audio_host_interface_tb;
    import pai_pkg::*;
    logic clk = 0, reset_n = 0, h_oe = 0, h_fr = 1, h_ir = 1, idsel = 0, gnt_n = 1;
    logic legacy_dma_grant = 0, ps_ack = 0, slow = 0, pm_rready = 1, pm_wvalid = 1, bad = 0;
    logic [31:0] h_ad = 0, ps_rdata = 32'h1357_9BDF, pm_wdata = 32'h2468_ACE0, rd, p_rd;
    logic [31:0] ad_in, ad_out, pm_rdata, tq, ma;
    logic [3:0] h_cbe = 0, cbe_in, cbe_out, p_cmd;
    logic [7:0] p_words;
    logic ad_oe, cbe_oe, frame_n_in, frame_n_out, frame_n_oe, irdy_n_in, irdy_n_out, irdy_n_oe;
    logic trdy_n_in, trdy_n_out, trdy_n_oe, devsel_n_in, devsel_n_out, devsel_n_oe;
    logic stop_n_in, stop_n_out, stop_n_oe, req_n, sig_target_abort, dma_gnt, vreg_gnt;
    logic pm_rvalid, pm_done, pm_err, p_dev, p_trdy, p_oe, p_roe;
    pai_io_win_t [NUM_WIN-1:0] io_map = '0;
    pai_ps_req_t ps_req;
    pai_pm_req_t dma_req = '0, vreg_req = '0;
    int err_total = 0, tests_run = 0;
    assign frame_n_in = frame_n_oe ? frame_n_out : h_oe ? h_fr : 1'b1;
    assign irdy_n_in = irdy_n_oe ? irdy_n_out : h_oe ? h_ir : 1'b1;
    assign trdy_n_in = trdy_n_oe ? trdy_n_out : p_oe ? p_trdy : 1'b1;
    assign devsel_n_in = devsel_n_oe ? devsel_n_out : p_oe ? p_dev : 1'b1;
    assign stop_n_in = stop_n_oe ? stop_n_out : 1'b1;
    assign cbe_in = cbe_oe ? cbe_out : h_cbe;
    assign ad_in = ad_oe ? ad_out : p_roe ? p_rd : h_ad;
    pai_pci_if u_pai_pci_if (.clk, .reset_n, .ad_in, .ad_out, .ad_oe, .cbe_in, .cbe_out, .cbe_oe,
        .frame_n_in, .frame_n_out, .frame_n_oe, .irdy_n_in, .irdy_n_out, .irdy_n_oe, .trdy_n_in,
        .trdy_n_out, .trdy_n_oe, .devsel_n_in, .devsel_n_out, .devsel_n_oe, .stop_n_in, .stop_n_out,
        .stop_n_oe, .idsel, .req_n, .gnt_n, .legacy_dma_grant, .io_map, .ps_req, .ps_ack, .ps_rdata,
        .sig_target_abort, .dma_req, .vreg_req, .dma_gnt, .vreg_gnt, .pm_wdata, .pm_wvalid,
        .pm_wready(), .pm_rdata, .pm_rvalid, .pm_rready, .pm_done, .pm_err);
    pai_far_agent u_pai_far_agent (.clk, .slow, .frame_n(frame_n_in), .irdy_n(irdy_n_in), .cbe(cbe_in),
        .devsel_n(p_dev), .trdy_n(p_trdy), .oe(p_oe), .rdata(p_rd), .rd_oe(p_roe), .cmd(p_cmd), .words(p_words));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        gnt_n <= req_n;
        if (pm_rvalid && pm_rready) rd <= pm_rdata;
        if (ad_oe && trdy_n_oe && !trdy_n_out) tq <= ad_in;
        if (cbe_oe && cbe_out[3:1] == 3'h3) ma <= ad_in;
        if (irdy_n_oe && !irdy_n_out && cbe_out !== BE_ALL) bad <= 1'b1;
        if ((dma_gnt || vreg_gnt) && devsel_n_oe && !devsel_n_out) bad <= 1'b1;
        if (dma_gnt && vreg_gnt) bad <= 1'b1;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic hcyc(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be, input logic id,
                        output logic d1, output logic d2, output logic ab);
        logic v;
        v = 0;
        ab = 0;
        @(posedge clk);
        {h_oe, h_fr, h_ad, h_cbe, idsel} <= {1'b1, 1'b0, a, c, id};
        @(posedge clk);
        {h_fr, h_ir, h_ad, h_cbe} <= {1'b1, 1'b0, 32'h5A5A_C3C3, be};
        #1 d1 = devsel_n_oe && !devsel_n_out;
        @(posedge clk);
        #1 d2 = devsel_n_oe && !devsel_n_out;
        repeat (12) begin
            @(posedge clk);
            ps_ack <= v;
            #1 v = ps_req.valid && !ps_ack;
            ab = ab | sig_target_abort;
            if (!trdy_n_in || !stop_n_in) break;
        end
        ab = ab && !stop_n_in && devsel_n_in;
        @(posedge clk);
        h_ir <= 1'b1;
        ps_ack <= 1'b0;
        @(posedge clk);
        h_oe <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : hcyc
    task automatic t_cmds;
        logic d1, d2, ab;
        for (int c = 0; c < 16; c++) begin
            hcyc(c[3:0], 32'h0000_0104, 4'hC, 1'b0, d1, d2, ab);
            `CHK("claim", (c == 2 || c == 3), d2)
            `CHK("medium", 1'b0, d1)
            if (c == 2) `CHK("rdata", ps_rdata, tq)
        end
        hcyc(CMD_IO_RD, 32'h0000_0204, 4'hC, 1'b0, d1, d2, ab);
        `CHK("miss", 1'b0, d2)
    endtask : t_cmds
    task automatic t_cfg;
        logic d1, d2, ab;
        hcyc(CMD_CFG_WR, 32'h0000_0100, 4'h0, 1'b1, d1, d2, ab);
        `CHK("cfg", 2'b10, {d2, ab})
        `CHK("psreq", {5'h19, 32'h0000_0100, 32'h5A5A_C3C3, 4'h0}, {ps_req.write, ps_req.cfg, ps_req.func, ps_req.addr, ps_req.data, ps_req.be_n})
        hcyc(CMD_CFG_RD, 32'h0000_0300, 4'h0, 1'b1, d1, d2, ab);
        `CHK("func", 1'b0, d2)
    endtask : t_cfg
    task automatic t_fast;
        logic d1, d2, ab;
        legacy_dma_grant <= 1'b1;
        hcyc(CMD_IO_WR, {16'h0000, LEGACY_ADDR1}, 4'hE, 1'b0, d1, d2, ab);
        `CHK("fast", 1'b1, d1)
        legacy_dma_grant <= 1'b0;
    endtask : t_fast
    task automatic t_abort;
        logic d1, d2, ab;
        hcyc(CMD_IO_WR, 32'h0000_0104, 4'h0, 1'b0, d1, d2, ab);
        `CHK("abort4", 1'b1, ab)
        hcyc(CMD_IO_RD, 32'h0000_0104, 4'h8, 1'b0, d1, d2, ab);
        `CHK("abort3", 1'b1, ab)
        hcyc(CMD_IO_WR, 32'h0000_0400, 4'hC, 1'b0, d1, d2, ab);
        `CHK("abort_byte", 2'b11, {d2, ab})
        hcyc(CMD_IO_RD, 32'h0000_0300, 4'hE, 1'b0, d1, d2, ab);
        `CHK("abort_word", 2'b11, {d2, ab})
        hcyc(CMD_IO_WR, 32'h0000_0302, 4'h3, 1'b0, d1, d2, ab);
        `CHK("codec", 2'b10, {d2, ab})
    endtask : t_abort
    task automatic t_master;
        @(posedge clk);
        dma_req <= '{1'b1, 1'b1, 32'hFFFF_FFF8, 8'h02};
        vreg_req <= '{1'b1, 1'b0, 32'h0000_0040, 8'h01};
        slow <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK("arb", 2'b10, {dma_gnt, vreg_gnt})
        dma_req.valid <= 1'b0;
        repeat (60) begin @(posedge clk); #1 if (pm_done === 1'b1) break; end
        `CHK("wr", {CMD_MEM_WR, 8'h02, 1'b0, 32'hFFFF_FFF8}, {p_cmd, p_words, pm_err, ma})
        repeat (60) begin @(posedge clk); #1 if (vreg_gnt === 1'b1) break; end
        vreg_req.valid <= 1'b0;
        repeat (60) begin @(posedge clk); #1 if (pm_done === 1'b1) break; end
        `CHK("rd", {CMD_MEM_RD, 32'hA5A5_A500, 1'b0, 32'h0000_0040}, {p_cmd, rd, pm_err, ma})
        `CHK("master", 1'b0, bad)
    endtask : t_master
    initial begin
        io_map[WIN_DMA] = '{1'b1, 16'h0100, 16'h000F};
        io_map[WIN_GAME] = '{1'b1, 16'h0400, 16'h0003};
        io_map[WIN_CODEC] = '{1'b1, 16'h0300, 16'h0003};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_cmds;
        t_cfg;
        t_fast;
        t_abort;
        t_master;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        conclude;
    end
endmodule : pci_audio_host_interface_tb
